// ---- iwc_core_model.sv ----
// Behavioural CPU core that takes vectors and returns from service
`timescale 1ns/1ps
module iwc_core_model #(
    parameter int ACC_LAG = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic halt,
    input wire logic vec_load,
    input wire logic ret_go,
    output logic accept,
    output logic ret
);
    logic [3:0] lag;
    logic busy;
    // Boundary comes only ACC_LAG run cycles after halt or service ends, so a take right after those is never instant
    assign accept = !halt && !busy && lag == 4'(ACC_LAG);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lag <= 4'h0;
        end else if (halt || busy) begin
            lag <= 4'h0;
        end else if (lag != 4'(ACC_LAG)) begin
            lag <= lag + 4'h1;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            ret <= 1'b0;
        end else begin
            ret <= busy && ret_go && !ret;
            if (vec_load) busy <= 1'b1;
            else if (ret) busy <= 1'b0;
        end
    end
endmodule : iwc_core_model

// ---- iwc_ctrl.sv ----
// Interrupt collection, vectoring and sleep/green wakeup control with AHB-Lite registers
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module iwc_ctrl #(
    parameter int WAKE_CLOCKS = iwc_pkg::WAKE_CLOCKS_DEF,
    parameter int ADDR_W = 10
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [ADDR_W-1:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic [7:0] PORT_ZERO,
    input wire logic [7:0] PORT_ONE,
    input wire logic HOSC_CLK,
    input wire logic TIMER_ZERO_OVF,
    input wire logic CAPTURE_TIMER_A_REQ,
    input wire logic CAPTURE_TIMER_B_REQ,
    input wire logic SERIAL_UNIT_REQ,
    input wire logic CONVERTER_REQ,
    input wire logic EXTRA_PERIPH_REQ,
    input wire logic SLEEP_ENTER,
    input wire logic GREEN_ENTER,
    input wire logic SLOW_MODE,
    input wire logic CORE_ACCEPT,
    input wire logic RETURN_FROM_IRQ,
    output logic IRQ_REQ,
    output logic VECTOR_LOAD,
    output logic [11:0] VECTOR_ADDR,
    output logic STACK_PUSH,
    output logic CPU_HALT,
    output logic HOSC_STOP,
    output logic RESUME_SLOW
);
    localparam int CW = $clog2(WAKE_CLOCKS + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(WAKE_CLOCKS - 1);

    // Register state
    logic [7:0] pin_wake_bits;
    logic [7:0] irq_enable;
    logic [7:0] irq_flags;
    logic extra_periph_en;
    logic extra_periph_flag;
    logic global_irq_enable;
    logic [2:0] stack_pointer_reg;

    logic [7:0] next_pin_wake_bits;
    logic [7:0] next_irq_enable;
    logic [7:0] next_irq_flags;
    logic next_extra_periph_en;
    logic next_extra_periph_flag;
    logic next_global_irq_enable;
    logic [2:0] next_stack_pointer_reg;

    // Bus data phase state
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [7:0] wdata;

    // Mode state
    iwc_pkg::iwc_mode_t mode;
    iwc_pkg::iwc_mode_t next_mode;
    logic [CW-1:0] settle_cnt;

    // Synchronised pins
    logic [7:0] p0_level;
    logic [7:0] p0_change;
    logic [7:0] p1_level;
    logic [7:0] p1_change;
    logic hosc_level;
    logic hosc_change;
    logic hosc_rise;

    logic wake_pins;
    logic asleep;
    logic take;
    logic [7:0] flag_set;
    logic [2:0] ext_set;
    logic [4:0] int_set;
    logic [31:0] rd_mux;
    logic addr_ok;
    logic [7:0] addr_idx;

    iwc_sync_edge #(.W(8)) u_sync_p0 (
        .clk(REF_CLK),
        .rst(RST),
        .din(PORT_ZERO),
        .level(p0_level),
        .change(p0_change)
    );

    iwc_sync_edge #(.W(8)) u_sync_p1 (
        .clk(REF_CLK),
        .rst(RST),
        .din(PORT_ONE),
        .level(p1_level),
        .change(p1_change)
    );

    iwc_sync_edge #(.W(1)) u_sync_hosc (
        .clk(REF_CLK),
        .rst(RST),
        .din(HOSC_CLK),
        .level(hosc_level),
        .change(hosc_change)
    );

    assign hosc_rise = hosc_change & hosc_level;

    // Bus slave: zero wait states, always OKAY
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign addr_idx = HADDR[9:2];
    assign addr_ok = HSEL && HTRANS[1] && HREADY;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            wr_pend <= 1'b0;
            wr_idx <= 8'h00;
        end else begin
            wr_pend <= addr_ok && HWRITE;
            wr_idx <= addr_idx;
        end
    end

    assign wdata = HWDATA[7:0];

    // Read data is taken from next values so a write just ahead is seen
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (addr_idx)
            iwc_pkg::IDX_FLAGS_EXT: rd_mux = {31'h0000_0000, next_extra_periph_flag};
            iwc_pkg::IDX_ENABLE_EXT: rd_mux = {31'h0000_0000, next_extra_periph_en};
            iwc_pkg::IDX_FLAGS: rd_mux = {24'h00_0000, next_irq_flags};
            iwc_pkg::IDX_ENABLE: rd_mux = {24'h00_0000, next_irq_enable};
            iwc_pkg::IDX_STACK: rd_mux = {24'h00_0000, next_global_irq_enable, 4'h0, next_stack_pointer_reg};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            HRDATA <= 32'h0000_0000;
        end else if (addr_ok && !HWRITE) begin
            HRDATA <= rd_mux;
        end
    end

    // Wake enables are write-only and never read back
    always_comb begin
        next_pin_wake_bits = pin_wake_bits;
        if (wr_pend && wr_idx == iwc_pkg::IDX_WAKE_EN) begin
            next_pin_wake_bits = wdata;
        end
    end

    always_comb begin
        next_irq_enable = irq_enable;
        next_extra_periph_en = extra_periph_en;
        if (wr_pend && wr_idx == iwc_pkg::IDX_ENABLE) begin
            next_irq_enable = wdata;
        end
        if (wr_pend && wr_idx == iwc_pkg::IDX_ENABLE_EXT) begin
            next_extra_periph_en = wdata[0];
        end
    end

    // Peripherals stand still in sleep, so their requests are ignored there
    assign asleep = (mode == iwc_pkg::ST_SLEEP) || (mode == iwc_pkg::ST_SETTLE);
    assign ext_set = p0_change[iwc_pkg::EXT_LINES-1:0] & irq_enable[iwc_pkg::EXT_LINES-1:0];
    assign int_set = {CONVERTER_REQ, CAPTURE_TIMER_B_REQ, CAPTURE_TIMER_A_REQ,
                      TIMER_ZERO_OVF, SERIAL_UNIT_REQ} & {5{~asleep}};
    assign flag_set = {int_set, ext_set};

    // A set arriving with a software clear wins
    always_comb begin
        next_irq_flags = irq_flags;
        next_extra_periph_flag = extra_periph_flag;
        if (wr_pend && wr_idx == iwc_pkg::IDX_FLAGS) begin
            next_irq_flags = wdata;
        end
        if (wr_pend && wr_idx == iwc_pkg::IDX_FLAGS_EXT) begin
            next_extra_periph_flag = wdata[0];
        end
        next_irq_flags = next_irq_flags | flag_set;
        next_extra_periph_flag = next_extra_periph_flag | (EXTRA_PERIPH_REQ & ~asleep);
    end

    // Requests stay pending through sleep and settle; vectoring waits for normal run
    assign IRQ_REQ = global_irq_enable && (mode == iwc_pkg::ST_RUN) &&
                     ((|(irq_flags & irq_enable)) || (extra_periph_flag && extra_periph_en));
    assign take = IRQ_REQ && CORE_ACCEPT;

    // Taking wins over a return in the same cycle
    always_comb begin
        next_global_irq_enable = global_irq_enable;
        next_stack_pointer_reg = stack_pointer_reg;
        if (wr_pend && wr_idx == iwc_pkg::IDX_STACK) begin
            next_global_irq_enable = wdata[iwc_pkg::GIE_BIT];
            next_stack_pointer_reg = wdata[2:0];
        end
        if (take) begin
            next_global_irq_enable = 1'b0;
            next_stack_pointer_reg = stack_pointer_reg - 3'h1;
        end else if (RETURN_FROM_IRQ) begin
            next_global_irq_enable = 1'b1;
            next_stack_pointer_reg = stack_pointer_reg + 3'h1;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            pin_wake_bits <= iwc_pkg::RST_BYTE;
            irq_enable <= iwc_pkg::RST_BYTE;
            extra_periph_en <= 1'b0;
        end else begin
            pin_wake_bits <= next_pin_wake_bits;
            irq_enable <= next_irq_enable;
            extra_periph_en <= next_extra_periph_en;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            irq_flags <= iwc_pkg::RST_BYTE;
            extra_periph_flag <= 1'b0;
        end else begin
            irq_flags <= next_irq_flags;
            extra_periph_flag <= next_extra_periph_flag;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            global_irq_enable <= 1'b0;
            stack_pointer_reg <= iwc_pkg::RST_STACK;
        end else begin
            global_irq_enable <= next_global_irq_enable;
            stack_pointer_reg <= next_stack_pointer_reg;
        end
    end

    // Vector strobe and stack push follow the take by one edge
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            VECTOR_LOAD <= 1'b0;
            STACK_PUSH <= 1'b0;
            VECTOR_ADDR <= 12'h000;
        end else begin
            VECTOR_LOAD <= take;
            STACK_PUSH <= take;
            VECTOR_ADDR <= iwc_pkg::VECTOR_ADDR_VAL;
        end
    end

    // Port zero always wakes, port one per pin
    assign wake_pins = (|p0_change) || (|(p1_change & pin_wake_bits));

    always_comb begin
        next_mode = mode;
        case (mode)
            iwc_pkg::ST_RUN: begin
                if (SLEEP_ENTER) begin
                    next_mode = iwc_pkg::ST_SLEEP;
                end else if (GREEN_ENTER) begin
                    next_mode = iwc_pkg::ST_GREEN;
                end
            end
            iwc_pkg::ST_GREEN: begin
                if (wake_pins || TIMER_ZERO_OVF) begin
                    next_mode = iwc_pkg::ST_RUN;
                end
            end
            iwc_pkg::ST_SLEEP: begin
                if (wake_pins) begin
                    next_mode = iwc_pkg::ST_SETTLE;
                end
            end
            iwc_pkg::ST_SETTLE: begin
                if (hosc_rise && settle_cnt == CNT_LAST) begin
                    next_mode = iwc_pkg::ST_RUN;
                end
            end
            default: next_mode = iwc_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            mode <= iwc_pkg::ST_RUN;
        end else begin
            mode <= next_mode;
        end
    end

    // Counts only oscillator edges seen after the wakeup
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            settle_cnt <= '0;
        end else if (mode != iwc_pkg::ST_SETTLE) begin
            settle_cnt <= '0;
        end else if (hosc_rise) begin
            settle_cnt <= settle_cnt + CW'(1);
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            CPU_HALT <= 1'b0;
            HOSC_STOP <= 1'b0;
        end else begin
            CPU_HALT <= (next_mode != iwc_pkg::ST_RUN);
            HOSC_STOP <= (next_mode == iwc_pkg::ST_SLEEP);
        end
    end

    // Green returns to the mode it left; sleep always returns to normal
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            RESUME_SLOW <= 1'b0;
        end else if (mode == iwc_pkg::ST_RUN && SLEEP_ENTER) begin
            RESUME_SLOW <= 1'b0;
        end else if (mode == iwc_pkg::ST_RUN && GREEN_ENTER) begin
            RESUME_SLOW <= SLOW_MODE;
        end
    end
endmodule : iwc_ctrl

// ---- iwc_ctrl_chk.sv ----
// Port-level checker for the interrupt and wakeup controller
`timescale 1ns/1ps
module iwc_ctrl_chk #(
    parameter int WAKE_CLOCKS = 4096
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic SLEEP_ENTER,
    input wire logic GREEN_ENTER,
    input wire logic SLOW_MODE,
    input wire logic CORE_ACCEPT,
    input wire logic IRQ_REQ,
    input wire logic VECTOR_LOAD,
    input wire logic [11:0] VECTOR_ADDR,
    input wire logic STACK_PUSH,
    input wire logic CPU_HALT,
    input wire logic HOSC_STOP,
    input wire logic RESUME_SLOW
);
    logic settling;
    logic [15:0] settle_cnt;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // Cycle count of the settle phase; each oscillator edge costs at least one core cycle
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            settling <= 1'b0;
            settle_cnt <= 16'h0;
        end else if ($fell(HOSC_STOP)) begin
            settling <= 1'b1;
            settle_cnt <= 16'h0;
        end else if (!CPU_HALT) begin
            settling <= 1'b0;
        end else begin
            settle_cnt <= settle_cnt + 16'h1;
        end
    end
    sequence take_s;
        IRQ_REQ && CORE_ACCEPT;
    endsequence
    sequence vector_s;
        VECTOR_LOAD && STACK_PUSH && VECTOR_ADDR == 12'h008 ##1 !VECTOR_LOAD && !STACK_PUSH;
    endsequence
    take_vector_a: assert property (take_s |=> vector_s)
        else $error("vector pulse missing after take");
    gie_drop_a: assert property (VECTOR_LOAD |-> !IRQ_REQ)
        else $error("request still high during service entry");
    halt_masks_a: assert property (CPU_HALT |-> !IRQ_REQ)
        else $error("request raised while halted");
    stop_halt_a: assert property (HOSC_STOP |-> CPU_HALT)
        else $error("oscillator stopped while running");
    sleep_stop_a: assert property (SLEEP_ENTER && !CPU_HALT |=> HOSC_STOP && CPU_HALT)
        else $error("sleep entry did not stop oscillator");
    green_run_a: assert property (GREEN_ENTER && !SLEEP_ENTER && !CPU_HALT
        |=> CPU_HALT && !HOSC_STOP && RESUME_SLOW == $past(SLOW_MODE))
        else $error("green entry wrong");
    wake_hold_a: assert property ($fell(HOSC_STOP) |-> CPU_HALT [*4])
        else $error("core released at wake edge");
    settle_len_a: assert property (settling && $fell(CPU_HALT) |-> settle_cnt >= WAKE_CLOCKS)
        else $error("settle phase too short");
    cover property (take_s);
endmodule : iwc_ctrl_chk

bind iwc_ctrl iwc_ctrl_chk #(.WAKE_CLOCKS(WAKE_CLOCKS)) u_chk (.REF_CLK, .RST, .SLEEP_ENTER, .GREEN_ENTER,
    .SLOW_MODE, .CORE_ACCEPT, .IRQ_REQ, .VECTOR_LOAD, .VECTOR_ADDR, .STACK_PUSH, .CPU_HALT, .HOSC_STOP, .RESUME_SLOW);

// ---- iwc_ctrl_tb.sv ----
// Self-checking testbench for the interrupt and wakeup controller
`timescale 1ns/1ps
module iwc_ctrl_tb;
    localparam int WK = 8;
    localparam logic [7:0] IX [7] = '{iwc_pkg::IDX_WAKE_EN, iwc_pkg::IDX_FLAGS_EXT, iwc_pkg::IDX_ENABLE_EXT,
        iwc_pkg::IDX_FLAGS, iwc_pkg::IDX_ENABLE, iwc_pkg::IDX_STACK, 8'h10};
    localparam logic [7:0] WV [7] = '{8'hff, 8'hff, 8'hff, 8'h5a, 8'ha5, 8'h05, 8'hff};
    localparam logic [7:0] RV [7] = '{8'h00, 8'h01, 8'h01, 8'h5a, 8'ha5, 8'h05, 8'h00};
    logic ref_clk = 1'b0, rst = 1'b1, hosc = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0, ret_go = 1'b0;
    logic [1:0] htrans = 2'h0, mgo = 2'h0;
    logic [9:0] haddr = 10'h0;
    logic [31:0] hwdata = 32'h0, hrdata;
    logic [7:0] p0 = 8'h0, p1 = 8'h0;
    logic [5:0] req = 6'h0;
    logic hready, hresp, accept, ret, irq, vload, spush, halt, hstop, rslow;
    logic [11:0] vaddr;
    int miscompares = 0, checks = 0, n;
    iwc_ctrl #(.WAKE_CLOCKS(WK)) dut (.REF_CLK(ref_clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
        .HRESP(hresp), .PORT_ZERO(p0), .PORT_ONE(p1), .HOSC_CLK(hosc), .TIMER_ZERO_OVF(req[0]),
        .CAPTURE_TIMER_A_REQ(req[1]), .CAPTURE_TIMER_B_REQ(req[2]), .SERIAL_UNIT_REQ(req[3]),
        .CONVERTER_REQ(req[4]), .EXTRA_PERIPH_REQ(req[5]), .SLEEP_ENTER(mgo[0]), .GREEN_ENTER(mgo[1]),
        .SLOW_MODE(slow), .CORE_ACCEPT(accept), .RETURN_FROM_IRQ(ret), .IRQ_REQ(irq), .VECTOR_LOAD(vload),
        .VECTOR_ADDR(vaddr), .STACK_PUSH(spush), .CPU_HALT(halt), .HOSC_STOP(hstop), .RESUME_SLOW(rslow));
    iwc_core_model #(.ACC_LAG(2)) core (.clk(ref_clk), .rst(rst), .halt(halt), .vec_load(vload),
        .ret_go(ret_go), .accept(accept), .ret(ret));
    initial forever #2.5 ref_clk = ~ref_clk;
    // Oscillator stands still while stopped, toggles on core clock falling edges, eight core clocks per period
    always #20 hosc = hstop ? 1'b0 : ~hosc;
    task automatic results();
        $display("Checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic bus(input logic [7:0] i, input logic w, input logic [7:0] d, output logic [31:0] r);
        int k;
        k = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {i, 2'h0};
        hwrite <= w;
        do begin @(posedge ref_clk); k++; end while (hready !== 1'b1 && k < 64);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do begin @(posedge ref_clk); k++; end while (hready !== 1'b1 && k < 64);
        r = hrdata;
        cmp("okay response", 32'h0, {31'h0, hresp});
        if (k >= 64) begin
            miscompares++;
            $display("Error bus ready expected 1 seen timeout");
            results();
        end
    endtask : bus
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [31:0] r;
        bus(i, 1'b1, d, r);
    endtask : wr
    task automatic rd(input logic [7:0] i, input logic [7:0] e);
        logic [31:0] r;
        bus(i, 1'b0, 8'h0, r);
        cmp($sformatf("register %h", i), {24'h0, e}, r);
    endtask : rd
    // Bounded wait on vector pulse, oscillator stop, halt or return pulse
    task automatic wt(input int s, input logic v, output int c);
        c = 0;
        while ((s == 0 ? vload : s == 1 ? hstop : s == 2 ? halt : ret) !== v && c < 400) begin
            @(posedge ref_clk);
            c++;
        end
        if (c >= 400) begin
            miscompares++;
            $display("Error wait %0d expected %b seen timeout", s, v);
            results();
        end
    endtask : wt
    task automatic pulse(input logic [5:0] r, input logic [1:0] m);
        req <= r;
        mgo <= m;
        @(posedge ref_clk);
        req <= 6'h0;
        mgo <= 2'h0;
        @(posedge ref_clk);
    endtask : pulse
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int k = 0; k < 7; k++) begin
            rd(IX[k], k == 5 ? 8'h07 : 8'h00);
            wr(IX[k], WV[k]);
            rd(IX[k], RV[k]);
            wr(IX[k], k == 5 ? 8'h07 : 8'h00);
        end
        $display("Test registers done");
        pulse(6'h3f, 2'h0);
        rd(iwc_pkg::IDX_FLAGS, 8'hf8);
        rd(iwc_pkg::IDX_FLAGS_EXT, 8'h01);
        wr(iwc_pkg::IDX_STACK, 8'h87);
        @(posedge ref_clk);
        cmp("request without enable", 32'h0, {31'h0, irq});
        wr(iwc_pkg::IDX_ENABLE, 8'h10);
        wt(0, 1'b1, n);
        cmp("vector address", 32'h8, {20'h0, vaddr});
        cmp("stack push", 32'h1, {31'h0, spush});
        cmp("request in service", 32'h0, {31'h0, irq});
        rd(iwc_pkg::IDX_STACK, 8'h06);
        wr(iwc_pkg::IDX_FLAGS, 8'h00);
        wr(iwc_pkg::IDX_FLAGS_EXT, 8'h00);
        ret_go <= 1'b1;
        wt(3, 1'b1, n);
        ret_go <= 1'b0;
        rd(iwc_pkg::IDX_STACK, 8'h87);
        // Extra peripheral alone must reach the shared vector
        wr(iwc_pkg::IDX_ENABLE_EXT, 8'h01);
        pulse(6'h20, 2'h0);
        wt(0, 1'b1, n);
        cmp("extra source vector", 32'h1, {31'h0, vload});
        wr(iwc_pkg::IDX_FLAGS_EXT, 8'h00);
        wr(iwc_pkg::IDX_ENABLE_EXT, 8'h00);
        ret_go <= 1'b1;
        wt(3, 1'b1, n);
        ret_go <= 1'b0;
        wr(iwc_pkg::IDX_STACK, 8'h07);
        wr(iwc_pkg::IDX_ENABLE, 8'h00);
        $display("Test vector done");
        p0 <= p0 ^ 8'h01;
        repeat (6) @(posedge ref_clk);
        rd(iwc_pkg::IDX_FLAGS, 8'h00);
        wr(iwc_pkg::IDX_ENABLE, 8'h07);
        p0 <= p0 ^ 8'h07;
        repeat (6) @(posedge ref_clk);
        rd(iwc_pkg::IDX_FLAGS, 8'h07);
        wr(iwc_pkg::IDX_FLAGS, 8'h00);
        $display("Test external lines done");
        wr(iwc_pkg::IDX_ENABLE, 8'h01);
        wr(iwc_pkg::IDX_WAKE_EN, 8'h01);
        pulse(6'h0, 2'h1);
        cmp("halt in sleep", 32'h1, {31'h0, halt});
        cmp("oscillator stop", 32'h1, {31'h0, hstop});
        p1 <= p1 ^ 8'h02;
        repeat (8) @(posedge ref_clk);
        cmp("disabled pin wake", 32'h1, {31'h0, hstop});
        p1 <= p1 ^ 8'h01;
        wt(1, 1'b0, n);
        wt(2, 1'b0, n);
        cmp("settle long enough", 32'h1, {31'h0, n >= 7 * WK});
        cmp("resume normal", 32'h0, {31'h0, rslow});
        pulse(6'h0, 2'h1);
        p0 <= p0 ^ 8'h01;
        wt(1, 1'b0, n);
        wt(2, 1'b0, n);
        rd(iwc_pkg::IDX_FLAGS, 8'h01);
        wr(iwc_pkg::IDX_FLAGS, 8'h00);
        $display("Test sleep done");
        slow <= 1'b1;
        pulse(6'h0, 2'h2);
        cmp("halt in green", 32'h1, {31'h0, halt});
        cmp("clock kept in green", 32'h0, {31'h0, hstop});
        cmp("resume slow", 32'h1, {31'h0, rslow});
        pulse(6'h01, 2'h0);
        cmp("green timer wake", 32'h0, {31'h0, halt});
        // Slow was the last mode here, so a sleep entry must still clear the return mode
        pulse(6'h0, 2'h1);
        cmp("sleep resumes normal", 32'h0, {31'h0, rslow});
        p0 <= p0 ^ 8'h02;
        wt(1, 1'b0, n);
        wt(2, 1'b0, n);
        slow <= 1'b0;
        pulse(6'h0, 2'h2);
        cmp("green resumes normal", 32'h0, {31'h0, rslow});
        p1 <= p1 ^ 8'h01;
        repeat (5) @(posedge ref_clk);
        cmp("green pin wake", 32'h0, {31'h0, halt});
        $display("Test green done");
        results();
    end
endmodule : iwc_ctrl_tb

// ---- iwc_pkg.sv ----
// Constants, register map and mode type for the interrupt and wakeup controller
// How it works
// - Sleep or green mode halts the core until a wakeup trigger arrives.
// - Sleep wakes only on port zero or enabled port one pin changes, into normal mode.
// - Green wakes on pin change or timer zero overflow, back to normal or slow.
// - Entering sleep stops the high-speed oscillator.
// - Sleep wakeup waits 4096 high-speed oscillator clocks before normal mode.
// - Green wakeup has no settling delay; its clock never stopped.
// - Port zero pins always wake; port one pins only with their enable bits.
// - Port one wake enables at 0C0H, bit n per pin, write-only, reset 0.
// - Nine request sources: six internal peripherals and three external lines.
// - An external request that wakes from sleep stays latched until normal mode.
// - Taking an interrupt clears the global enable.
// - Return from interrupt sets the global enable again.
// - Taking an interrupt pushes the stack and loads vector address 8.
// - Enable register 0C9H: lines a,b,c bits 0-2; serial,timer0,capA,capB,converter bits 3-7.
// - Extra peripheral enable sits in bit 0 of 0C7H, read-write, reset 0.
// - Hardware sets flags in 0C8H at enable bit positions; software clears them.
// - Extra peripheral flag sits in bit 0 of 0C6H, read-write, reset 0.
// - Global enable is bit 7 of 0DFH, read-write, reset 0.
// - An external line flag is not set while its enable bit is clear.
// - Timer zero flag sets on overflow regardless of enable; vector needs enable.
package iwc_pkg;
    // Register indices; the bus byte address is four times the index
    localparam logic [7:0] IDX_WAKE_EN = 8'hc0;
    localparam logic [7:0] IDX_FLAGS_EXT = 8'hc6;
    localparam logic [7:0] IDX_ENABLE_EXT = 8'hc7;
    localparam logic [7:0] IDX_FLAGS = 8'hc8;
    localparam logic [7:0] IDX_ENABLE = 8'hc9;
    localparam logic [7:0] IDX_STACK = 8'hdf;
    localparam int GIE_BIT = 7;
    localparam int EXT_LINES = 3;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_STACK = 3'h7;
    localparam logic [11:0] VECTOR_ADDR_VAL = 12'h008;
    localparam int WAKE_CLOCKS_DEF = 4096;
    typedef enum logic [1:0] {ST_RUN, ST_GREEN, ST_SLEEP, ST_SETTLE} iwc_mode_t;
endpackage : iwc_pkg

// ---- iwc_sync_edge.sv ----
// Two-flop synchroniser with level-change detection
`timescale 1ns/1ps
module iwc_sync_edge #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] level,
    output logic [W-1:0] change
);
    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] prev;

    // First stage feeds only the second stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            stable <= '0;
            prev <= '0;
        end else begin
            meta <= din;
            stable <= meta;
            prev <= stable;
        end
    end

    assign level = stable;
    assign change = stable ^ prev;
endmodule : iwc_sync_edge
